/* File: logic/dma_controller.sv */
// Four-channel DMA controller with APB register slave and memory bus master
`timescale 1ns/100ps
`default_nettype none
`include "dma_defs.svh"

module dma_controller (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [255:0] periphEvents,
   input  wire logic [63:0] periphIndAddr,
   output logic             busReq,
   output logic             busWrite,
   output logic             busByte,
   output logic [15:0]      busAddr,
   output logic [15:0]      busWdata,
   input  wire logic        busAck,
   input  wire logic [15:0] busRdata,
   output logic             irq
);
   dma_pkg::dma_state_type s;
   dma_pkg::dma_state_type next_s;

   // ****************************************
   // Helpers
   // ****************************************
   // Memory side address of a channel
   function automatic logic [15:0] memAddr(input dma_pkg::chan_type c,
                                           input logic [15:0] indAddr);
      logic [15:0] base;
      base = (c.cfg.pingPong && c.ppSel) ? c.staB : c.staA;
      unique case (c.cfg.addrMode)
         dma_pkg::AM_POST_INC: memAddr = base + c.ofs;
         dma_pkg::AM_PERIPH:   memAddr = indAddr;
         default:              memAddr = base;
      endcase
   endfunction

   // Peripheral register preloaded when a source is selected
   function automatic logic [15:0] defaultPad(input logic [7:0] code);
      unique case (code)
         `SRC_CAPTURE_TWO:   defaultPad = `PAD_CAPTURE_TWO;
         `SRC_COMPARE_TWO:   defaultPad = `PAD_COMPARE_TWO_PRI;
         `SRC_SERIAL_ONE_TX: defaultPad = `PAD_SERIAL_ONE_TX;
         `SRC_ANALOG_ONE:    defaultPad = `PAD_ANALOG_ONE;
         `SRC_CAN_ONE_TX:    defaultPad = `PAD_CAN_ONE_TX;
         default:            defaultPad = `DMA_RESET_WORD;
      endcase
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [1:0]  ci;
      logic [16:0] cnt1;
      logic [16:0] halfPt;
      logic        granted;
      logic [15:0] ind;
      ci      = paddr[6:5];
      cnt1    = 17'h00000;
      halfPt  = 17'h00000;
      granted = 1'b0;
      ind     = 16'h0000;
      next_s  = s;
      next_s.apb.pready  = 1'b0;
      next_s.apb.pslverr = 1'b0;

      // Setup phase: decode now so the access phase answers at once
      if (psel && !penable) begin
         next_s.apb.pready = 1'b1;
         next_s.apb.prdata = 32'h00000000;
         if (paddr[1:0] != 2'h0) begin
            next_s.apb.pslverr = 1'b1;
         end else if (!paddr[`DMA_GLOBAL_BIT]) begin
            unique case (paddr[4:0])
               `DMA_CTRL_OFS: next_s.apb.prdata = {25'h0000000, s.ch[ci].cfg};
               `DMA_REQ_OFS:  next_s.apb.prdata = {24'h000000, s.ch[ci].reqSel};
               `DMA_STA_OFS:  next_s.apb.prdata = {16'h0000, s.ch[ci].staA};
               `DMA_STB_OFS:  next_s.apb.prdata = {16'h0000, s.ch[ci].staB};
               `DMA_PAD_OFS:  next_s.apb.prdata = {16'h0000, s.ch[ci].pad};
               `DMA_CNT_OFS:  next_s.apb.prdata = {16'h0000, s.ch[ci].blockLen};
               default:       next_s.apb.pslverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               `DMA_STATUS_ADDR: next_s.apb.prdata = {24'h000000, s.status};
               `DMA_MASK_ADDR:   next_s.apb.prdata = {24'h000000, s.mask};
               `DMA_STATE_ADDR: begin
                  for (int i = 0; i < `DMA_CHANNELS; i++) begin
                     next_s.apb.prdata[i]     = s.ch[i].cfg.enable;
                     next_s.apb.prdata[4 + i] = s.ch[i].pending;
                  end
                  next_s.apb.prdata[9:8] = s.act;
                  next_s.apb.prdata[10]  = (s.fsm != dma_pkg::ST_IDLE);
               end
               default: next_s.apb.pslverr = 1'b1;
            endcase
         end
      end

      // Access phase completes on this edge
      if (psel && penable && s.apb.pready && !s.apb.pslverr) begin
         if (!pwrite && paddr == `DMA_STATUS_ADDR) begin
            next_s.status = 8'h00;
         end
         if (pwrite && !paddr[`DMA_GLOBAL_BIT]) begin
            unique case (paddr[4:0])
               `DMA_CTRL_OFS: begin
                  next_s.ch[ci].cfg = pwdata[6:0];
                  if (pwdata[0] && !s.ch[ci].cfg.enable) begin
                     next_s.ch[ci].done  = 16'h0000;
                     next_s.ch[ci].ofs   = 16'h0000;
                     next_s.ch[ci].ppSel = 1'b0;
                  end
               end
               `DMA_REQ_OFS: begin
                  next_s.ch[ci].reqSel = pwdata[7:0];
                  next_s.ch[ci].pad    = defaultPad(pwdata[7:0]);
                  if (pwdata[`DMA_FORCE_BIT] && s.ch[ci].cfg.enable) begin
                     next_s.ch[ci].pending = 1'b1;
                  end
               end
               `DMA_STA_OFS: next_s.ch[ci].staA = pwdata[15:0];
               `DMA_STB_OFS: next_s.ch[ci].staB = pwdata[15:0];
               `DMA_PAD_OFS: next_s.ch[ci].pad = pwdata[15:0];
               `DMA_CNT_OFS: next_s.ch[ci].blockLen = pwdata[15:0];
               default: ;
            endcase
         end else if (pwrite && paddr == `DMA_MASK_ADDR) begin
            next_s.mask = pwdata[7:0];
         end
      end

      // ****************************************
      // Transfer engine
      // ****************************************
      unique case (s.fsm)
         dma_pkg::ST_IDLE: begin
            for (int i = `DMA_CHANNELS - 1; i >= 0; i--) begin
               if (s.ch[i].pending && s.ch[i].cfg.enable) begin
                  next_s.act = 2'(i);
                  granted    = 1'b1;
               end
            end
            if (granted) begin
               ind = periphIndAddr[16 * next_s.act +: 16];
               next_s.ch[next_s.act].pending = 1'b0;
               next_s.bus.req   = 1'b1;
               next_s.bus.write = 1'b0;
               next_s.bus.byteSize = s.ch[next_s.act].cfg.byteSize;
               next_s.bus.addr = s.ch[next_s.act].cfg.toPeriph
                                 ? memAddr(s.ch[next_s.act], ind)
                                 : s.ch[next_s.act].pad;
               next_s.fsm = dma_pkg::ST_READ;
            end
         end
         dma_pkg::ST_READ: begin
            if (busAck) begin
               ind = periphIndAddr[16 * s.act +: 16];
               next_s.bus.write = 1'b1;
               next_s.bus.wdata = busRdata;
               next_s.bus.addr  = s.ch[s.act].cfg.toPeriph ? s.ch[s.act].pad
                                  : memAddr(s.ch[s.act], ind);
               next_s.fsm = dma_pkg::ST_WRITE;
            end
         end
         dma_pkg::ST_WRITE: begin
            if (busAck) begin
               next_s.bus.req = 1'b0;
               next_s.fsm     = dma_pkg::ST_IDLE;
               cnt1   = {1'b0, s.ch[s.act].done} + 17'h00001;
               halfPt = ({1'b0, s.ch[s.act].blockLen} + 17'h00001) >> 1;
               next_s.ch[s.act].done = cnt1[15:0];
               if (s.ch[s.act].cfg.addrMode == dma_pkg::AM_POST_INC) begin
                  next_s.ch[s.act].ofs = s.ch[s.act].ofs
                                         + (s.ch[s.act].cfg.byteSize ? 16'h0001 : 16'h0002);
               end
               if (cnt1 == halfPt && halfPt != 17'h00000) begin
                  next_s.status[`DMA_HALF_LSB + s.act] = 1'b1;
               end
               if (s.ch[s.act].done == s.ch[s.act].blockLen) begin
                  next_s.status[s.act]  = 1'b1;
                  next_s.ch[s.act].done = 16'h0000;
                  next_s.ch[s.act].ofs  = 16'h0000;
                  if (s.ch[s.act].cfg.pingPong) begin
                     next_s.ch[s.act].ppSel = !s.ch[s.act].ppSel;
                  end
                  if (!s.ch[s.act].cfg.autoRepeat) begin
                     next_s.ch[s.act].cfg.enable = 1'b0;
                  end
               end
            end
         end
      endcase

      // latch requests, set wins over grant
      for (int i = 0; i < `DMA_CHANNELS; i++) begin
         if (next_s.ch[i].cfg.enable && periphEvents[s.ch[i].reqSel]) begin
            next_s.ch[i].pending = 1'b1;
         end
      end
      next_s.irq = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s     <= '0;
         s.fsm <= dma_pkg::ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign prdata   = s.apb.prdata;
   assign pready   = s.apb.pready;
   assign pslverr  = s.apb.pslverr;
   assign busReq   = s.bus.req;
   assign busWrite = s.bus.write;
   assign busByte  = s.bus.byteSize;
   assign busAddr  = s.bus.addr;
   assign busWdata = s.bus.wdata;
   assign irq      = s.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Completion strobes shared by several properties
   logic fullEvt0;
   logic fullEvt3;
   logic stepEvt0;
   assign fullEvt0 = s.fsm == dma_pkg::ST_WRITE && busAck && s.act == 2'h0
                     && s.ch[0].done == s.ch[0].blockLen;
   assign stepEvt0 = s.fsm == dma_pkg::ST_WRITE && busAck && s.act == 2'h0;
   assign fullEvt3 = s.fsm == dma_pkg::ST_WRITE && busAck && s.act == 2'h3
                     && s.ch[3].done == s.ch[3].blockLen;

   AST_ONE_DIR: assert property (
      (s.fsm == dma_pkg::ST_READ && !s.ch[s.act].cfg.toPeriph) |-> busAddr == s.ch[s.act].pad)
      else $error("Peripheral-to-memory channel did not read its peripheral");
   AST_PRIORITY: assert property (
      (s.fsm == dma_pkg::ST_IDLE && s.ch[0].pending && s.ch[0].cfg.enable)
      |=> (s.act == 2'h0 && s.fsm == dma_pkg::ST_READ))
      else $error("Channel zero lost arbitration");
   AST_PENDING_HOLD: assert property (
      (s.ch[2].pending && s.fsm != dma_pkg::ST_IDLE) |=> s.ch[2].pending)
      else $error("Pending request dropped while not granted");
   AST_FULL_IRQ: assert property (
      fullEvt0 |=> s.status[0] && (s.irq || !s.mask[0]))
      else $error("Full block flag missing");
   AST_HALF_IRQ: assert property (
      (stepEvt0 && s.ch[0].blockLen == 16'h0003 && s.ch[0].done == 16'h0001)
      |=> s.status[`DMA_HALF_LSB])
      else $error("Half block flag missing");
   AST_POST_INC: assert property (
      (stepEvt0 && !fullEvt0 && s.ch[0].cfg.addrMode == dma_pkg::AM_POST_INC)
      |=> s.ch[0].ofs == $past(s.ch[0].ofs)
          + ($past(s.ch[0].cfg.byteSize) ? 16'h0001 : 16'h0002))
      else $error("Post-increment step wrong");
   AST_PERIPH_ADDR: assert property (
      (s.fsm == dma_pkg::ST_READ && busAck && s.act == 2'h0
       && !s.ch[0].cfg.toPeriph && s.ch[0].cfg.addrMode == dma_pkg::AM_PERIPH)
      |=> busAddr == $past(periphIndAddr[15:0]))
      else $error("Peripheral-indirect address not used");
   AST_BYTE_SIZE: assert property (
      (s.fsm == dma_pkg::ST_READ) |-> busByte == s.ch[s.act].cfg.byteSize)
      else $error("Transfer size differs from channel setting");
   AST_ONESHOT: assert property (
      (fullEvt0 && !s.ch[0].cfg.autoRepeat) |=> !s.ch[0].cfg.enable)
      else $error("One-shot channel still enabled");
   AST_PINGPONG: assert property (
      (fullEvt3 && s.ch[3].cfg.pingPong) |=> s.ch[3].ppSel != $past(s.ch[3].ppSel))
      else $error("Ping-pong buffer did not swap");
   AST_SOURCE_SEL: assert property (
      (s.ch[2].cfg.enable && periphEvents[s.ch[2].reqSel] && !(psel && pwrite))
      |=> s.ch[2].pending || s.act == 2'h2)
      else $error("Selected source request lost");

   AST_REPEAT: assert property (
      (fullEvt3 && s.ch[3].cfg.autoRepeat && !(psel && pwrite)) |=> s.ch[3].cfg.enable)
      else $error("Auto-repeat channel stopped after its block");
   AST_MOVE: assert property (
      (s.fsm == dma_pkg::ST_READ && busAck)
      |=> (busReq && busWrite && busWdata == $past(busRdata)))
      else $error("Read data not carried into the write phase");
   AST_BUS_HOLD: assert property (
      (busReq && !busAck) |=> busReq && $stable(busAddr) && $stable(busWrite) && $stable(busByte))
      else $error("Memory request changed before its acknowledge");
   AST_FORCE: assert property (
      (psel && penable && pready && !pslverr && pwrite && paddr == {3'h3, `DMA_REQ_OFS}
       && pwdata[`DMA_FORCE_BIT] && s.ch[3].cfg.enable) |=> s.ch[3].pending)
      else $error("Software force did not raise a request");

   // ****************************************
   // Cover points
   // ****************************************
   COV_FULL_BLOCK: cover property (fullEvt0 ##1 irq);
   COV_PINGPONG: cover property (fullEvt3 && s.ch[3].cfg.pingPong);
   COV_CONTENTION: cover property (s.ch[1].pending && s.ch[2].pending);
   COV_HALF_BLOCK: cover property (stepEvt0 && s.ch[0].done == 16'h0001);
endmodule // dma_controller
`default_nettype wire

/* File: logic/dma_defs.svh */
// Register map, field positions, reset values and request codes of the DMA controller
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH
`define DMA_CHANNELS        4
`define DMA_GLOBAL_BIT      7
`define DMA_CH_LSB          5
`define DMA_CTRL_OFS        5'h00
`define DMA_REQ_OFS         5'h04
`define DMA_STA_OFS         5'h08
`define DMA_STB_OFS         5'h0C
`define DMA_PAD_OFS         5'h10
`define DMA_CNT_OFS         5'h14
`define DMA_STATUS_ADDR     8'h80
`define DMA_MASK_ADDR       8'h84
`define DMA_STATE_ADDR      8'h88
`define DMA_FORCE_BIT       8
`define DMA_HALF_LSB        4
`define DMA_RESET_WORD      16'h0000
`define SRC_EXT_IRQ_ZERO    8'h00
`define SRC_CAPTURE_TWO     8'h05
`define SRC_COMPARE_TWO     8'h06
`define SRC_TIMER_TWO       8'h07
`define SRC_SERIAL_ONE_TX   8'h0C
`define SRC_ANALOG_ONE      8'h0D
`define SRC_CAN_ONE_TX      8'h46
`define PAD_CAPTURE_TWO     16'h014C
`define PAD_COMPARE_TWO_PRI 16'h0910
`define PAD_COMPARE_TWO_SEC 16'h090E
`define PAD_SERIAL_ONE_TX   16'h0224
`define PAD_ANALOG_ONE      16'h0300
`define PAD_CAN_ONE_TX      16'h0442
`endif

/* File: logic/dma_pkg.sv */
// Types of the DMA controller
`default_nettype none
package dma_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } xfer_state_type;

   typedef enum logic [1:0] {
      AM_POST_INC = 2'h0,
      AM_NO_INC   = 2'h1,
      AM_PERIPH   = 2'h2
   } addr_mode_type;

   typedef struct packed {
      logic          pingPong;
      logic          autoRepeat;
      addr_mode_type addrMode;
      logic          byteSize;
      logic          toPeriph;
      logic          enable;
   } chan_cfg_type;

   typedef struct packed {
      chan_cfg_type cfg;
      logic [7:0]   reqSel;
      logic [15:0]  staA;
      logic [15:0]  staB;
      logic [15:0]  pad;
      logic [15:0]  blockLen;
      logic [15:0]  done;
      logic [15:0]  ofs;
      logic         ppSel;
      logic         pending;
   } chan_type;

   typedef struct packed {
      logic        req;
      logic        write;
      logic        byteSize;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bus_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_resp_type;

   typedef struct packed {
      chan_type [3:0] ch;
      xfer_state_type fsm;
      logic [1:0]     act;
      bus_req_type    bus;
      apb_resp_type   apb;
      logic [7:0]     status;
      logic [7:0]     mask;
      logic           irq;
   } dma_state_type;
endpackage
`default_nettype wire

/* File: tb/sram_model.sv */
// Memory and peripheral register space answering the DMA memory bus
`timescale 1ns/100ps
`default_nettype none
module sram_model (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        slow,
   input  wire logic        busReq,
   input  wire logic        busWrite,
   input  wire logic        busByte,
   input  wire logic [15:0] busAddr,
   input  wire logic [15:0] busWdata,
   output var  logic        busAck,
   output var  logic [15:0] busRdata
);
   logic [15:0] mem [0:32767];
   logic [15:0] word;
   logic [1:0]  waited;
   assign word = mem[busAddr[15:1]];
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busAck   <= 1'b0;
         waited   <= 2'h0;
         busRdata <= 16'hFFFF;
      end else begin
         busAck   <= 1'b0;
         // Stale read data toggles so it never passes for a fresh value
         busRdata <= ~busRdata;
         if (busReq && !busAck && (!slow || waited == 2'h3)) begin
            busAck <= 1'b1;
            waited <= 2'h0;
            if (!busWrite)
               busRdata <= busByte ? {8'h00, busAddr[0] ? word[15:8] : word[7:0]} : word;
            else if (!busByte)
               mem[busAddr[15:1]] <= busWdata;
            else if (busAddr[0])
               mem[busAddr[15:1]][15:8] <= busWdata[7:0];
            else
               mem[busAddr[15:1]][7:0] <= busWdata[7:0];
         end else if (busReq && !busAck)
            waited <= waited + 2'h1;
      end
   end
endmodule // sram_model
`default_nettype wire

/* File: tb/test_four_channel_dma_controller.sv */
// Self-checking bench of the four-channel DMA controller
`timescale 1ns/100ps
`default_nettype none
`include "dma_defs.svh"
module test_four_channel_dma_controller;
   logic          clk, reset_n, psel, penable, pwrite, pready, pslverr, er, slow;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [255:0]  periphEvents;
   logic [63:0]   periphIndAddr;
   logic          busReq, busWrite, busByte, busAck, irq;
   logic [15:0]   busAddr, busWdata, busRdata;
   logic [31:0]   wq[$];
   int            miscompares, checksDone;
   logic [23:0]   rows [7] = '{24'h000000, 24'h05014C, 24'h060910, 24'h070000,
                               24'h0C0224, 24'h0D0300, 24'h460442};

   dma_controller dma_controller_inst (.clk(clk), .reset_n(reset_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periphEvents(periphEvents),
      .periphIndAddr(periphIndAddr), .busReq(busReq), .busWrite(busWrite),
      .busByte(busByte), .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck),
      .busRdata(busRdata), .irq(irq));
   sram_model sram_model_inst (.clk(clk), .reset_n(reset_n), .slow(slow), .busReq(busReq),
      .busWrite(busWrite), .busByte(busByte), .busAddr(busAddr), .busWdata(busWdata),
      .busAck(busAck), .busRdata(busRdata));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
      if (busReq === 1'b1 && busAck === 1'b1 && busWrite === 1'b1)
         wq.push_back({busAddr, busWdata});

   task automatic closeOut;
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cfg(input logic [1:0] c, input logic [7:0] code,
                      input logic [15:0] pad, a, b, n, ctrl);
      apb(1'b1, {1'b0, c, `DMA_REQ_OFS}, {8'h00, code});
      apb(1'b1, {1'b0, c, `DMA_PAD_OFS}, pad);
      apb(1'b1, {1'b0, c, `DMA_STA_OFS}, a);
      apb(1'b1, {1'b0, c, `DMA_STB_OFS}, b);
      apb(1'b1, {1'b0, c, `DMA_CNT_OFS}, n);
      apb(1'b1, {1'b0, c, `DMA_CTRL_OFS}, ctrl);
   endtask
   task automatic pulse(input logic [7:0] code);
      @(posedge clk);
      periphEvents[code] <= 1'b1;
      @(posedge clk);
      periphEvents[code] <= 1'b0;
   endtask
   task automatic waitWrites(input int n);
      for (int k = 0; k < 400 && wq.size() < n; k++)
         @(posedge clk);
      repeat (3) @(posedge clk);
   endtask

   // Hang guard, far beyond the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      closeOut();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, slow} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      periphEvents = '0;
      periphIndAddr = 64'h0000000000001234;
      sram_model_inst.mem[16'h0180] = 16'hA5C3;
      sram_model_inst.mem[16'h0112] = 16'h7E01;
      sram_model_inst.mem[16'h1800] = 16'hC0DE;
      sram_model_inst.mem[16'h2000] = 16'h5A11;
      sram_model_inst.mem[16'h2008] = 16'h0033;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      check("irq", 32'h0, irq);
      check("busReq", 32'h0, busReq);
      apb(1'b0, `DMA_STATE_ADDR, 16'h0000);
      check("state", 32'h0, rd);
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, {3'h0, `DMA_REQ_OFS}, {8'h00, rows[i][23:16]});
         apb(1'b0, {3'h0, `DMA_PAD_OFS}, 16'h0000);
         check("preload", {16'h0000, rows[i][15:0]}, rd);
      end
      $display("test source table done");
      apb(1'b1, `DMA_MASK_ADDR, 16'h00FF);
      cfg(2'd0, 8'h0D, 16'h0300, 16'h1000, 16'h0000, 16'h0003, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         pulse(8'h0D);
         waitWrites(i + 1);
         check("dst", {16'h1000 + 16'(2 * i), 16'hA5C3}, wq[i]);
         if (i == 1) begin
            check("irq", 32'h1, irq);
            apb(1'b0, `DMA_STATUS_ADDR, 16'h0000);
            check("status", 32'h10, rd);
         end
      end
      apb(1'b0, `DMA_STATUS_ADDR, 16'h0000);
      check("status", 32'h01, rd);
      repeat (2) @(posedge clk);
      check("irq", 32'h0, irq);
      pulse(8'h0D);
      repeat (20) @(posedge clk);
      check("count", 32'd4, wq.size());
      $display("test block done");
      wq.delete();
      cfg(2'd1, 8'h07, 16'h0224, 16'h2000, 16'h0000, 16'h0000, 16'h0001);
      cfg(2'd2, 8'h07, 16'h0224, 16'h3000, 16'h0000, 16'h0000, 16'h0003);
      pulse(8'h07);
      waitWrites(2);
      check("first", {16'h2000, 16'h7E01}, wq[0]);
      check("second", {16'h0224, 16'hC0DE}, wq[1]);
      apb(1'b0, `DMA_STATUS_ADDR, 16'h0000);
      check("status", 32'h06, rd);
      $display("test priority done");
      wq.delete();
      slow <= 1'b1;
      apb(1'b1, `DMA_MASK_ADDR, 16'h0000);
      cfg(2'd3, 8'h0C, 16'h0224, 16'h4001, 16'h4010, 16'h0000, 16'h006F);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, {3'h3, `DMA_REQ_OFS}, 16'h010C);
         waitWrites(i + 1);
         check("pingpong", {16'h0224, i[0] ? 8'h33 : 8'h5A}, {wq[i][31:16], wq[i][7:0]});
      end
      check("irq", 32'h0, irq);
      apb(1'b0, `DMA_STATUS_ADDR, 16'h0000);
      check("status", 32'h08, rd);
      slow <= 1'b0;
      $display("test ping-pong done");
      wq.delete();
      apb(1'b1, {3'h0, `DMA_CTRL_OFS}, 16'h0000);
      cfg(2'd0, 8'h00, 16'h0300, 16'h0000, 16'h0000, 16'h0000, 16'h0011);
      pulse(8'h00);
      waitWrites(1);
      check("indirect", {16'h1234, 16'hA5C3}, wq[0]);
      $display("test indirect done");
      apb(1'b0, 8'hA0, 16'h0000);
      check("slverr", 32'h1, er);
      check("rdata", 32'h0, rd);
      apb(1'b0, 8'h18, 16'h0000);
      check("slverr", 32'h1, er);
      $display("test unmapped done");
      closeOut();
   end
endmodule // test_four_channel_dma_controller
`default_nettype wire
